// ### rtl/sar_adc_regs.svh
// register offsets, field positions, reset values and timing counts of the converter
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH
`define ADC_CTRL0_OFS 4'h0
`define ADC_CTRL1_OFS 4'h1
`define ADC_RESH_OFS 4'h2
`define ADC_RESL_OFS 4'h3
`define ADC_FLAG_OFS 4'h4
`define ADC_IEN_OFS 4'h5
`define ADC_ON_BIT 0
`define ADC_GO_BIT 1
`define ADC_CHS_LSB 2
`define ADC_PREF_LSB 0
`define ADC_NREF_BIT 2
`define ADC_CLK_LSB 4
`define ADC_FMT_BIT 7
`define ADC_FLAG_BIT 0
`define ADC_IE_BIT 0
`define ADC_PIE_BIT 1
`define ADC_GIE_BIT 2
`define ADC_REG_RST 8'h00
`define ADC_CLK_NS 10
`define ADC_INSTR_NS 40
`define ADC_INSTR_CLKS ((`ADC_INSTR_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)
`define ADC_HALF_TADS 23
`define ADC_SAR_MSB 10'h200
`define ADC_CH_PA 6'h00
`define ADC_CH_PB 6'h08
`define ADC_CH_PC 6'h10
`define ADC_CH_PORT_N 6'h07
`define ADC_CH_TEMP 6'h3c
`define ADC_CH_DAC 6'h3d
`define ADC_CH_FVR 6'h3e
`define ADC_CH_GND 6'h3f
`endif

// ### rtl/sar_adc_pkg.sv
// types shared by the converter control logic
package sar_adc_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} conv_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [5:0] channel_select;
    logic channel_valid;
    logic [1:0] positive_reference_select;
    logic negative_reference_select;
    logic sample;
    logic [9:0] dac_code;
    logic power;
  } analog_ctrl_t;

  typedef struct packed {
    conv_state_t st;
    logic [2:0] dly;
    logic [5:0] div;
    logic [4:0] half;
    logic [2:0] conv_sel;
    logic [9:0] sar;
    logic [5:0] chs;
    logic on;
    logic go;
    logic fmt;
    logic [2:0] clk_sel;
    logic nref;
    logic [1:0] pref;
    logic [7:0] res_h;
    logic [7:0] res_l;
    logic flag;
    logic ie;
    logic pie;
    logic global_irq_enable;
    logic shut;
    logic [7:0] rdata;
    logic wake;
    logic vec;
  } adc_state_t;

endpackage

// ### rtl/sar_adc_conversion_control.sv
// control logic of a 10-bit successive-approximation converter
//
// How it works
// R1 - six-bit channel field in control register zero routes one source to sample-hold
// R2 - sources: seven inputs each of ports a, b, c, temperature, dac, fixed ref, ground
// R3 - software waits a settling delay after changing channel before starting
// R4 - software selects ground channel before stepping down from a higher voltage
// R5 - two-bit field picks ref pin, supply, 2.048V or 4.096V; 4.096V absent on low-voltage
// R6 - one bit picks negative reference pin or device ground
// R7 - three-bit clock field divides system clock 2..64 or picks the rc clock
// R8 - one conversion lasts 11.5 bit periods
// R9 - divided conversion clock follows the system clock; rc clock is independent
// R10 - software selects the rc clock for conversions during sleep
// R11 - done flag set at every completion regardless of the interrupt enable
// R12 - hardware never clears the done flag; software clears it
// R13 - completion in sleep with interrupt enabled wakes; vectors when all enables set
// R14 - justify bit places result left or right across the result pair
// R15 - converter works only while on; writing one to go starts a conversion
// R16 - software must not turn on and set go in the same write
// R17 - completion clears go, sets the flag and loads both result registers
// R18 - reset returns all registers to reset values and ends any conversion
// R19 - with rc clock, start is delayed one instruction cycle after go
// R20 - sleep, rc clock, interrupt off: converter powers down after completion, on kept
// R21 - sleep with divided clock aborts conversion and powers down, on bit kept
// R22 - result found by successive approximation into the result pair
// R23 - go reads one for the whole conversion
// R24 - fixed channel code map; unassigned codes select no input
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "sar_adc_regs.svh"

module sar_adc_conversion_control #(
  parameter bit LOW_VOLTAGE = 1'b0
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input sar_adc_pkg::reg_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire sleep_i,
  input wire rc_tick_i,
  input wire comparator_i,
  output sar_adc_pkg::analog_ctrl_t analog_o,
  output logic wake_o,
  output logic isr_vector_o
);

  // ==========================================================================
  // functions
  // half bit period minus one, in system clocks
  function automatic logic [5:0] half_reload(input logic [2:0] sel);
    logic [5:0] r;
    r = 6'h00;
    case (sel)
      3'b000: r = 6'h00;
      3'b100: r = 6'h01;
      3'b001: r = 6'h03;
      3'b101: r = 6'h07;
      3'b010: r = 6'h0f;
      3'b110: r = 6'h1f;
      default: r = 6'h00;
    endcase
    return r;
  endfunction

  function automatic logic ch_valid(input logic [5:0] c);
    logic v;
    v = 1'b0;
    if (c >= `ADC_CH_PA && c < `ADC_CH_PA + `ADC_CH_PORT_N) v = 1'b1; // R2
    if (c >= `ADC_CH_PB && c < `ADC_CH_PB + `ADC_CH_PORT_N) v = 1'b1; // R2
    if (c >= `ADC_CH_PC && c < `ADC_CH_PC + `ADC_CH_PORT_N) v = 1'b1; // R2
    if (c >= `ADC_CH_TEMP) v = 1'b1; // R2
    return v; // R24
  endfunction

  // keep or drop the trial bit, then try the next lower one
  function automatic logic [9:0] sar_step(input logic [9:0] s, input logic [3:0] idx,
                                          input logic cmp);
    logic [9:0] r;
    logic [3:0] b;
    r = s;
    b = 4'd9 - idx;
    if (!cmp) r[b] = 1'b0;
    if (b != 4'd0) r[b - 4'd1] = 1'b1;
    return r;
  endfunction

  // ==========================================================================
  // state
  sar_adc_pkg::adc_state_t q;
  sar_adc_pkg::adc_state_t d;
  logic done_evt;
  logic tick;
  logic rc_run;
  logic in_conv;

  assign rc_run = (q.conv_sel[1:0] == 2'b11);
  assign in_conv = (q.st == sar_adc_pkg::ST_CONV);

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    done_evt = 1'b0;
    tick = 1'b0;
    d.wake = 1'b0;
    d.vec = 1'b0;
    d.rdata = 8'h00;
    if (!sleep_i) d.shut = 1'b0;
    // conversion sequencing
    case (q.st)
      sar_adc_pkg::ST_IDLE: begin
      end
      sar_adc_pkg::ST_DELAY: begin
        if (q.dly == 3'h0) begin
          d.st = sar_adc_pkg::ST_CONV; // R19
          d.div = half_reload(q.conv_sel);
          d.half = 5'h00;
        end else begin
          d.dly = q.dly - 3'h1;
        end
      end
      sar_adc_pkg::ST_CONV: begin
        if (rc_run) begin
          tick = rc_tick_i; // R9
        end else if (q.div == 6'h00) begin
          tick = 1'b1;
          d.div = half_reload(q.conv_sel); // R7 R9
        end else begin
          d.div = q.div - 6'h01;
        end
        if (tick) begin
          d.half = q.half + 5'h01;
          if (q.half[0] && q.half < 5'd20) begin
            d.sar = sar_step(q.sar, q.half[4:1], comparator_i); // R22
          end
          if (q.half == 5'(`ADC_HALF_TADS - 1)) begin
            done_evt = 1'b1; // R8
          end
        end
      end
      default: d.st = sar_adc_pkg::ST_IDLE;
    endcase
    if (done_evt) begin
      d.st = sar_adc_pkg::ST_IDLE;
      d.go = 1'b0; // R17
      if (q.fmt) begin
        d.res_h = q.sar[9:2]; // R14
        d.res_l = {q.sar[1:0], 6'h00}; // R14
      end else begin
        d.res_h = {6'h00, q.sar[9:8]}; // R14
        d.res_l = q.sar[7:0]; // R14
      end
      if (sleep_i && q.ie) begin
        d.wake = 1'b1; // R13
        d.vec = q.pie && q.global_irq_enable; // R13
      end
      if (sleep_i && rc_run && !q.ie) d.shut = 1'b1; // R20
    end
    // register writes
    if (bus_i.wr) begin
      case (bus_i.addr)
        `ADC_CTRL0_OFS: begin
          d.chs = bus_i.wdata[`ADC_CHS_LSB +: 6]; // R1
          d.on = bus_i.wdata[`ADC_ON_BIT];
          if (q.st != sar_adc_pkg::ST_IDLE &&
              (!bus_i.wdata[`ADC_GO_BIT] || !bus_i.wdata[`ADC_ON_BIT])) begin
            d.st = sar_adc_pkg::ST_IDLE; // R15
            d.go = 1'b0;
          end
          if (bus_i.wdata[`ADC_GO_BIT] && bus_i.wdata[`ADC_ON_BIT] && q.on && !q.shut &&
              q.st == sar_adc_pkg::ST_IDLE) begin
            d.go = 1'b1; // R15 R16 R23
            d.conv_sel = q.clk_sel;
            d.sar = `ADC_SAR_MSB;
            d.half = 5'h00;
            d.div = half_reload(q.clk_sel);
            if (q.clk_sel[1:0] == 2'b11) begin
              d.st = sar_adc_pkg::ST_DELAY; // R19
              d.dly = 3'(`ADC_INSTR_CLKS - 1);
            end else begin
              d.st = sar_adc_pkg::ST_CONV;
            end
          end
        end
        `ADC_CTRL1_OFS: begin
          d.fmt = bus_i.wdata[`ADC_FMT_BIT]; // R14
          d.clk_sel = bus_i.wdata[`ADC_CLK_LSB +: 3]; // R7
          d.nref = bus_i.wdata[`ADC_NREF_BIT]; // R6
          d.pref = bus_i.wdata[`ADC_PREF_LSB +: 2]; // R5
        end
        `ADC_FLAG_OFS: begin
          if (!bus_i.wdata[`ADC_FLAG_BIT]) d.flag = 1'b0; // R12
        end
        `ADC_IEN_OFS: begin
          d.ie = bus_i.wdata[`ADC_IE_BIT];
          d.pie = bus_i.wdata[`ADC_PIE_BIT];
          d.global_irq_enable = bus_i.wdata[`ADC_GIE_BIT];
        end
        default: begin
        end
      endcase
    end
    // sleep with a divided clock stops everything
    if (sleep_i && q.clk_sel[1:0] != 2'b11) begin
      d.shut = 1'b1; // R21
      if (q.st == sar_adc_pkg::ST_CONV && !rc_run) begin
        d.st = sar_adc_pkg::ST_IDLE; // R21
        d.go = 1'b0;
      end
    end
    // set wins over a same-cycle clear
    if (done_evt) d.flag = 1'b1; // R11 R17
    // register reads
    if (bus_i.rd) begin
      case (bus_i.addr)
        `ADC_CTRL0_OFS: d.rdata = {q.chs, q.go, q.on}; // R23
        `ADC_CTRL1_OFS: d.rdata = {q.fmt, q.clk_sel, 1'b0, q.nref, q.pref};
        `ADC_RESH_OFS: d.rdata = q.res_h;
        `ADC_RESL_OFS: d.rdata = q.res_l;
        `ADC_FLAG_OFS: d.rdata = {7'h00, q.flag};
        `ADC_IEN_OFS: d.rdata = {5'h00, q.global_irq_enable, q.pie, q.ie};
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      q <= '0; // R18
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign rdata_o = q.rdata;
  assign wake_o = q.wake;
  assign isr_vector_o = q.vec;
  assign analog_o.channel_select = q.chs; // R1
  assign analog_o.channel_valid = ch_valid(q.chs); // R24
  // 4.096V code falls back to supply where it does not exist
  assign analog_o.positive_reference_select =
    (LOW_VOLTAGE && q.pref == 2'b11) ? 2'b01 : q.pref; // R5
  assign analog_o.negative_reference_select = q.nref; // R6
  assign analog_o.sample = !in_conv || q.half == 5'h00;
  assign analog_o.dac_code = q.sar;
  assign analog_o.power = q.on && !q.shut; // R15 R20 R21

  // ==========================================================================
  // checks
  sequence s_rc_go;
    bus_i.wr && bus_i.addr == `ADC_CTRL0_OFS && bus_i.wdata[`ADC_GO_BIT] &&
    bus_i.wdata[`ADC_ON_BIT] && q.on && !q.shut && q.st == sar_adc_pkg::ST_IDLE &&
    q.clk_sel[1:0] == 2'b11;
  endsequence

  sequence s_done_sleep_wake;
    done_evt && sleep_i && q.ie;
  endsequence

  a_rc_start_delay: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R19
    s_rc_go |=> (!in_conv) [*4])
    else $error("rc conversion started without the instruction delay");

  a_conv_length: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R8
    done_evt && q.conv_sel == 3'b000 |-> $past(in_conv, 22) && !$past(in_conv, 23))
    else $error("divide-by-two conversion not 23 cycles long");

  a_done_effects: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R17
    done_evt |=> !q.go && q.flag && q.st == sar_adc_pkg::ST_IDLE)
    else $error("completion did not clear go and set flag");

  a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R12
    $fell(q.flag) |-> $past(bus_i.wr && bus_i.addr == `ADC_FLAG_OFS &&
                            !bus_i.wdata[`ADC_FLAG_BIT]))
    else $error("done flag cleared without software");

  a_busy_go: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R23
    q.st != sar_adc_pkg::ST_IDLE |-> q.go && q.on)
    else $error("conversion running without go or on");

  a_sleep_abort: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R21
    sleep_i && q.clk_sel[1:0] != 2'b11 && in_conv && !rc_run |=>
      q.st == sar_adc_pkg::ST_IDLE && !analog_o.power)
    else $error("sleep did not abort divided-clock conversion");

  a_wake_vector: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R13
    s_done_sleep_wake |=> wake_o && (isr_vector_o == $past(q.pie && q.global_irq_enable)))
    else $error("completion in sleep did not wake correctly");

  a_rc_shutoff: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R20
    done_evt && sleep_i && rc_run && !q.ie |=> !analog_o.power)
    else $error("converter not powered down after sleep conversion");

  a_result_format: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R14
    done_evt |=> q.res_h == ($past(q.fmt) ? $past(q.sar[9:2]) : {6'h00, $past(q.sar[9:8])}))
    else $error("result high byte misplaced");

  a_reset_clears: assert property (@(posedge ref_clk_i) // R18
    !rstn_i |=> q.st == sar_adc_pkg::ST_IDLE && !q.on && !q.go && !q.flag)
    else $error("reset left converter state");

  sequence s_go_taken;
    bus_i.wr && bus_i.addr == `ADC_CTRL0_OFS && bus_i.wdata[`ADC_GO_BIT] &&
    bus_i.wdata[`ADC_ON_BIT] && q.on && !q.shut && q.st == sar_adc_pkg::ST_IDLE;
  endsequence

  a_start_trial: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R22
    s_go_taken |=> q.go && analog_o.dac_code == `ADC_SAR_MSB)
    else $error("conversion did not start from the top trial bit");

  a_go_needs_on: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R16
    bus_i.wr && bus_i.addr == `ADC_CTRL0_OFS && !q.on |=> !q.go)
    else $error("go taken in the write that turned the converter on");

  a_abort_keeps: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R15
    bus_i.wr && bus_i.addr == `ADC_CTRL0_OFS && !bus_i.wdata[`ADC_GO_BIT] && in_conv &&
      !done_evt |=> q.st == sar_adc_pkg::ST_IDLE && $stable(q.res_h) && $stable(q.res_l) &&
      $stable(q.flag))
    else $error("abort changed the result or the flag");

  a_div_rate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R7
    in_conv && !rc_run && q.div != 6'h00 |=> $stable(q.half))
    else $error("divided clock advanced between its ticks");

  a_rc_pace: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R9
    in_conv && rc_run && !rc_tick_i |=> $stable(q.half))
    else $error("rc conversion advanced without an rc tick");

  a_wake_pulse: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R13
    wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");

  a_awake_no_wake: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R13
    done_evt && !sleep_i |=> !wake_o && !isr_vector_o)
    else $error("wake raised outside sleep");

  a_channel_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R1
    bus_i.wr && bus_i.addr == `ADC_CTRL0_OFS |=>
      analog_o.channel_select == $past(bus_i.wdata[`ADC_CHS_LSB +: 6]))
    else $error("channel select not taken from control register zero");

  a_ref_select: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R6
    bus_i.wr && bus_i.addr == `ADC_CTRL1_OFS |=>
      analog_o.negative_reference_select == $past(bus_i.wdata[`ADC_NREF_BIT]))
    else $error("negative reference select not taken from control register one");

endmodule // sar_adc_conversion_control

// ### test/sar_adc_analog_model.sv
// sample-hold and comparator model for the converter's analog side
`timescale 1ns/10ps

module sar_adc_analog_model (
  input wire ref_clk_i,
  input sar_adc_pkg::analog_ctrl_t analog_i,
  input wire logic [9:0] vin_i,
  output logic comparator_o
);
  logic [9:0] held_q;
  logic junk_q;

  // held value follows the input only while tracking
  always @(posedge ref_clk_i) begin
    if (analog_i.sample) begin
      held_q <= vin_i;
    end
    junk_q <= ~junk_q;
  end

  initial junk_q = 1'b0;

  // unpowered comparator gives no stable answer
  assign comparator_o = analog_i.power ? (held_q >= analog_i.dac_code) : junk_q;
endmodule // sar_adc_analog_model

// ### test/tb_sar_adc_conversion_control.sv
// self-checking testbench of the converter control logic
`timescale 1ns/10ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end

module tb_sar_adc_conversion_control;
  logic clk, rstn, sleep, cmp, rc_en;
  logic rc_tick = 1'b0;
  logic wake_seen = 1'b0;
  logic isr_seen = 1'b0;
  logic [9:0] vin;
  logic [7:0] rdata, v;
  logic [2:0] rc_cnt = 3'h0;
  int failures, num_checks;
  sar_adc_pkg::reg_req_t bus;
  sar_adc_pkg::analog_ctrl_t ana;
  logic wake, isr;

  sar_adc_conversion_control DUT (.ref_clk_i(clk), .rstn_i(rstn), .bus_i(bus), .rdata_o(rdata),
    .sleep_i(sleep), .rc_tick_i(rc_tick), .comparator_i(cmp), .analog_o(ana),
    .wake_o(wake), .isr_vector_o(isr));
  sar_adc_analog_model MODEL (.ref_clk_i(clk), .analog_i(ana), .vin_i(vin), .comparator_o(cmp));

  // ==========================================
  // clock, rc ticks, pulse catchers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick <= rc_en && (rc_cnt == 3'h4);
    if (wake === 1'b1) wake_seen <= 1'b1;
    if (isr === 1'b1) isr_seen <= 1'b1;
  end

  // ==========================================
  // bus tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    // read data stand through this cycle; take them at its closing edge
    @(posedge clk);
    v = rdata;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset;
    for (int a = 0; a < 7; a++) begin
      rd(a[3:0]);
      `CHK("reset reg", 8'h00, v)
    end
  endtask

  task automatic t_clocks;
    logic [2:0] code [6] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110};
    int div;
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h01);
    for (int i = 0; i < 6; i++) begin
      div = 2 << i;
      wr(4'h4, 8'h00);
      wr(4'h1, {1'b0, code[i], 4'h0});
      wr(4'h0, 8'h03);
      repeat (23 * div / 2 - 5) @(posedge clk);
      rd(4'h0);
      `CHK("busy", 8'h03, v)
      repeat (5) @(posedge clk);
      rd(4'h0);
      `CHK("done", 8'h01, v)
      rd(4'h4);
      `CHK("flag", 8'h01, v)
      rd(4'h2);
      `CHK("res high", {6'h00, vin[9:8]}, v)
      rd(4'h3);
      `CHK("res low", vin[7:0], v)
    end
  endtask

  task automatic t_left;
    wr(4'h1, 8'h80);
    wr(4'h0, 8'h03);
    repeat (30) @(posedge clk);
    rd(4'h2);
    `CHK("left high", vin[9:2], v)
    rd(4'h3);
    `CHK("left low", {vin[1:0], 6'h00}, v)
  endtask

  task automatic t_start_flag;
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h02);
    rd(4'h0);
    `CHK("go while off", 8'h00, v)
    wr(4'h0, 8'h03);
    rd(4'h0);
    `CHK("on and go", 8'h01, v)
    wr(4'h4, 8'h01);
    rd(4'h4);
    `CHK("flag kept", 8'h01, v)
    wr(4'h4, 8'h00);
    rd(4'h4);
    `CHK("flag cleared", 8'h00, v)
    wr(4'h0, 8'h03);
    wr(4'h0, 8'h01);
    repeat (30) @(posedge clk);
    rd(4'h4);
    `CHK("abort flag", 8'h00, v)
    rd(4'h0);
    `CHK("abort go", 8'h01, v)
  endtask

  task automatic t_select;
    logic [5:0] c [4] = '{6'h07, 6'h3f, 6'h12, 6'h2a};
    logic ok [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {c[i], 2'b01});
      @(posedge clk);
      `CHK("channel", c[i], ana.channel_select)
      `CHK("valid", ok[i], ana.channel_valid)
    end
    wr(4'h1, 8'h07);
    @(posedge clk);
    `CHK("pref", 2'h3, ana.positive_reference_select)
    `CHK("nref", 1'b1, ana.negative_reference_select)
    wr(4'h0, 8'h01);
    repeat (8) @(posedge clk);
  endtask

  task automatic t_sleep;
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h03);
    repeat (3) @(posedge clk);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("abort power", 1'b0, ana.power)
    rd(4'h0);
    `CHK("on kept", 1'b1, v[0])
    repeat (30) @(posedge clk);
    rd(4'h4);
    `CHK("no flag", 8'h00, v)
    sleep <= 1'b0;
    wr(4'h5, 8'h07);
    wr(4'h1, 8'h30);
    wr(4'h0, 8'h03);
    sleep <= 1'b1;
    rc_en <= 1'b1;
    for (int n = 0; n < 400 && !wake_seen; n++) @(posedge clk);
    `CHK("wake", 1'b1, wake_seen)
    `CHK("vector", 1'b1, isr_seen)
    sleep <= 1'b0;
    rd(4'h2);
    `CHK("rc high", {6'h00, vin[9:8]}, v)
    wr(4'h5, 8'h00);
    wr(4'h0, 8'h03);
    sleep <= 1'b1;
    repeat (200) @(posedge clk);
    `CHK("rc off power", 1'b0, ana.power)
    rd(4'h0);
    `CHK("rc on kept", 8'h01, v)
    sleep <= 1'b0;
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    rstn = 1'b0;
    bus = '0;
    sleep = 1'b0;
    rc_en = 1'b0;
    vin = 10'h2a5;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_clocks();
    t_left();
    t_start_flag();
    t_select();
    t_sleep();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule // tb_sar_adc_conversion_control
